// ==== common/reset_seq_pkg.sv ====
// constants for the reset source sequencer
// assumes one 250 MHz clock; detector, pin and oscillator inputs are asynchronous
package reset_seq_pkg;
  localparam logic [15:0] option_select_byte_addr = 16'hffff;
  localparam int          vmon0_off_bit           = 5;
  localparam logic [7:0]  option_erased_value     = 8'hff;
  localparam int          release_count           = 32;
  localparam int          cpu_clock_div           = 8;
  localparam int          pin_min_low_ns          = 10000;
  localparam int          clock_period_ns         = 4;
  localparam int          pin_min_low_cycles      = (pin_min_low_ns + clock_period_ns - 1) / clock_period_ns;
  localparam int          port_pin_count          = 20;
  localparam int          port4_output_index      = 10;
  localparam logic [2:0]  cause_pin               = 3'h0;
  localparam logic [2:0]  cause_vmon0             = 3'h1;
  localparam logic [2:0]  cause_vmon1             = 3'h2;
  localparam logic [2:0]  cause_vmon2             = 3'h3;
  localparam logic [2:0]  cause_watchdog          = 3'h4;
  localparam logic [2:0]  cause_software          = 3'h5;
  typedef enum logic [1:0] {
    seq_hold    = 2'b00,
    seq_count   = 2'b01,
    seq_release = 2'b10,
    seq_run     = 2'b11
  } seq_state_t;
endpackage

// ==== rtl/release_counter.sv ====
// counts slow oscillator edges while the supply sits above threshold zero
// assumes osc_tick_in is a one-cycle pulse on clock_in
module release_counter #(
  parameter int count_target = reset_seq_pkg::release_count
) (
  input  wire logic clock_in,
  input  wire logic reset_n_in,
  input  wire logic clear_in,
  input  wire logic osc_tick_in,
  output logic      done_out
);
  import reset_seq_pkg::*;
  initial begin
    if (count_target < 1 || count_target > 255) begin
      $error("count_target out of range");
    end
  end
  typedef struct packed {
    logic [7:0] count;
    logic       done;
  } cnt_state_t;
  cnt_state_t s_reg;
  cnt_state_t s_next;
  always_comb begin
    s_next = s_reg;
    if (clear_in) begin
      s_next.count = 8'h00;
      s_next.done  = 1'b0;
    end else if (osc_tick_in && !s_reg.done) begin
      s_next.count = s_reg.count + 8'h01;
      if (s_reg.count == 8'(count_target - 1)) begin
        s_next.done = 1'b1;
      end
    end
  end
  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end
  assign done_out = s_reg.done;
endmodule

// ==== rtl/reset_source_sequencer.sv ====
// reset source collector and release sequencer
// assumes detectors, pin and slow oscillator are asynchronous to clock_in
module reset_source_sequencer #(
  parameter int count_target = reset_seq_pkg::release_count,
  parameter int pin_count    = reset_seq_pkg::port_pin_count
) (
  input  wire logic                 clock_in,
  input  wire logic                 reset_n_in,
  input  wire logic                 reset_pin_n_in,
  input  wire logic                 slow_osc_in,
  input  wire logic                 vmon0_low_in,
  input  wire logic                 vmon1_low_in,
  input  wire logic                 vmon2_low_in,
  input  wire logic                 vmon1_reset_enable_in,
  input  wire logic                 vmon2_reset_enable_in,
  input  wire logic                 watchdog_underflow_in,
  input  wire logic                 watchdog_reset_select_in,
  input  wire logic                 software_reset_bit_in,
  input  wire logic                 vmon0_reset_enable_in,
  input  wire logic                 vmon0_reset_mode_select_in,
  input  wire logic                 detect0_circuit_enable_in,
  input  wire logic [7:0]           flash_option_byte_in,
  input  wire logic                 flash_block_erased_in,
  output logic                      system_reset_n_out,
  output logic                      sfr_reset_n_out,
  output logic                      fetch_reset_vector_out,
  output logic [2:0]                reset_cause_out,
  output logic [7:0]                option_select_byte_out,
  output logic                      cpu_clock_enable_out,
  output logic [pin_count-1:0]      port_output_enable_out,
  output logic                      ram_write_block_out
);
  import reset_seq_pkg::*;
  initial begin
    if (pin_count <= port4_output_index) begin
      $error("pin_count too small");
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers
  logic [1:0] pin_sync_reg;
  logic [1:0] osc_sync_reg;
  logic [1:0] v0_sync_reg;
  logic [1:0] v1_sync_reg;
  logic [1:0] v2_sync_reg;
  logic       osc_prev_reg;
  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      pin_sync_reg <= 2'h0;
      osc_sync_reg <= 2'h0;
      v0_sync_reg  <= 2'h3;
      v1_sync_reg  <= 2'h0;
      v2_sync_reg  <= 2'h0;
      osc_prev_reg <= 1'b0;
    end else begin
      pin_sync_reg <= {pin_sync_reg[0], reset_pin_n_in};
      osc_sync_reg <= {osc_sync_reg[0], slow_osc_in};
      v0_sync_reg  <= {v0_sync_reg[0], vmon0_low_in};
      v1_sync_reg  <= {v1_sync_reg[0], vmon1_low_in};
      v2_sync_reg  <= {v2_sync_reg[0], vmon2_low_in};
      osc_prev_reg <= osc_sync_reg[1];
    end
  end
  logic pin_low;
  logic osc_tick;
  logic v0_low;
  assign pin_low  = !pin_sync_reg[1];
  assign osc_tick = osc_sync_reg[1] && !osc_prev_reg;
  assign v0_low   = v0_sync_reg[1];

  ////////////////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    seq_state_t  state;
    logic [7:0]  option_byte;
    logic        vmon0_armed;
    logic        pin_was_low;
    logic        sys_rst_n;
    logic        sfr_rst_n;
    logic        fetch;
    logic [2:0]  cause;
    logic [2:0]  div_count;
    logic        cpu_en;
    logic [15:0] low_time;
    logic [pin_count-1:0] port_oe;
    logic        ram_block;
  } seq_reg_t;
  seq_reg_t s_reg;
  seq_reg_t s_next;

  logic count_clear;
  logic count_done;
  logic vmon0_active;
  logic src_pin;
  logic src_v0;
  logic src_v1;
  logic src_v2;
  logic src_wdt;
  logic src_sw;
  logic any_src;

  function automatic logic [7:0] option_value(input logic erased, input logic [7:0] stored);
    option_value = erased ? option_erased_value : stored;
  endfunction

  assign vmon0_active = !s_reg.option_byte[vmon0_off_bit] && s_reg.vmon0_armed && vmon0_reset_enable_in
                        && vmon0_reset_mode_select_in && detect0_circuit_enable_in;
  assign src_pin = pin_low;
  assign src_v0  = vmon0_active && v0_low;
  assign src_v1  = vmon1_reset_enable_in && v1_sync_reg[1];
  assign src_v2  = vmon2_reset_enable_in && v2_sync_reg[1];
  assign src_wdt = watchdog_reset_select_in && watchdog_underflow_in;
  assign src_sw  = software_reset_bit_in;
  assign any_src = src_pin || src_v0 || src_v1 || src_v2 || src_wdt || src_sw;
  assign count_clear = v0_low || !(s_reg.state == seq_count);

  release_counter #(
    .count_target (count_target)
  ) u_release_counter (
    .clock_in    (clock_in),
    .reset_n_in  (reset_n_in),
    .clear_in    (count_clear),
    .osc_tick_in (osc_tick),
    .done_out    (count_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // sequencer
  always_comb begin
    s_next = s_reg;
    s_next.fetch = 1'b0;
    if (pin_low) begin
      s_next.pin_was_low = 1'b1;
      // option byte is latched from flash only; no store path exists
      s_next.option_byte = option_value(flash_block_erased_in, flash_option_byte_in);
      s_next.low_time = (s_reg.low_time == 16'hffff) ? s_reg.low_time : s_reg.low_time + 16'h0001;
    end else begin
      s_next.low_time = 16'h0000;
    end
    if (s_reg.state != seq_run) begin
      s_next.div_count = 3'h0;
    end else if (osc_tick) begin
      s_next.div_count = s_reg.div_count + 3'h1;
    end
    s_next.cpu_en = osc_tick && s_reg.div_count == 3'(cpu_clock_div - 1) && s_reg.state == seq_run;
    unique case (s_reg.state)
      seq_hold: begin
        s_next.sys_rst_n = 1'b0;
        s_next.ram_block = 1'b1;
        s_next.port_oe = '0;
        s_next.port_oe[port4_output_index] = pin_low;
        if (!any_src) begin
          if (v0_low || !s_reg.pin_was_low && vmon0_active) begin
            s_next.state = seq_count;
          end else begin
            s_next.state = seq_release;
          end
        end
      end
      seq_count: begin
        s_next.port_oe = '0;
        if (any_src) begin
          s_next.state = seq_hold;
        end else if (count_done) begin
          s_next.state = seq_release;
        end
      end
      seq_release: begin
        if (any_src) begin
          s_next.state       = seq_hold;
        end else begin
          s_next.sys_rst_n   = 1'b1;
          s_next.sfr_rst_n   = 1'b1;
          s_next.ram_block   = 1'b0;
          s_next.fetch       = 1'b1;
          s_next.vmon0_armed = 1'b1;
          s_next.pin_was_low = 1'b0;
          s_next.div_count   = 3'h0;
          s_next.state       = seq_run;
        end
      end
      seq_run: begin
        if (any_src) begin
          s_next.state     = seq_hold;
          s_next.sys_rst_n = 1'b0;
          s_next.ram_block = 1'b1;
          s_next.sfr_rst_n = !(src_pin || src_v0);
          s_next.cause = src_pin ? cause_pin : src_v0 ? cause_vmon0 : src_v1 ? cause_vmon1 :
                         src_v2 ? cause_vmon2 : src_wdt ? cause_watchdog : cause_software;
        end
      end
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      s_reg <= '0;
      s_reg.option_byte <= 8'hff;
      s_reg.vmon0_armed <= 1'b1;
      s_reg.cause <= 3'h0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign system_reset_n_out     = s_reg.sys_rst_n;
  assign sfr_reset_n_out        = s_reg.sfr_rst_n;
  assign fetch_reset_vector_out = s_reg.fetch;
  assign reset_cause_out        = s_reg.cause;
  assign option_select_byte_out = s_reg.option_byte;
  assign cpu_clock_enable_out   = s_reg.cpu_en;
  assign port_output_enable_out = s_reg.port_oe;
  assign ram_write_block_out    = s_reg.ram_block;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  a_pin_holds_reset: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    pin_low |=> !system_reset_n_out) else $error("reset released while pin low");
  a_release_fetch: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    $rose(system_reset_n_out) |-> fetch_reset_vector_out) else $error("no fetch at release");
  a_port4_drives: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    (s_reg.state == seq_hold && pin_low) |=> port_output_enable_out[port4_output_index])
    else $error("port4 not driven");
  a_cpu_clk_div: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    cpu_clock_enable_out |=> !cpu_clock_enable_out) else $error("cpu enable too long");
  a_count_blocks: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    (s_reg.state == seq_count && !count_done && !any_src) |=> s_reg.state == seq_count)
    else $error("count left early");
  a_vmon0_gate: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    s_reg.option_byte[vmon0_off_bit] |-> !src_v0) else $error("vmon0 active with option set");
  a_sw_reset: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    (s_reg.state == seq_run && software_reset_bit_in) |=> !system_reset_n_out)
    else $error("software reset missed");
  a_wdt_reset: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    (s_reg.state == seq_run && watchdog_underflow_in && watchdog_reset_select_in) |=> !system_reset_n_out)
    else $error("watchdog reset missed");
  a_erased_option: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    (pin_low && flash_block_erased_in) |=> option_select_byte_out == option_erased_value)
    else $error("erased option not ones");
  c_pin_cycle: cover property (@(posedge clock_in) disable iff (!reset_n_in) pin_low ##[1:20] fetch_reset_vector_out);
  c_vmon0_count: cover property (@(posedge clock_in) disable iff (!reset_n_in) s_reg.state == seq_count ##1 count_done);
  c_software: cover property (@(posedge clock_in) disable iff (!reset_n_in) src_sw && s_reg.state == seq_run);
endmodule

// ==== verification/reset_pin_driver.sv ====
// model of the external reset circuit that drives the reset pin
// assumes one clock; the pin has a pull-up, so a released pin reads high
module reset_pin_driver #(
  parameter int low_cycles    = reset_seq_pkg::pin_min_low_cycles,
  parameter int settle_cycles = 50
) (
  input  wire logic clock_in,
  input  wire logic supply_valid_in,
  input  wire logic request_in,
  output logic      pin_n_out,
  output logic      busy_out
);
  timeunit 1ns;
  timeprecision 1ps;
  int count = 0;
  initial pin_n_out = 1'b0;
  assign busy_out = (count != 0);
  ////////////////////////////////////////////////////////////////
  always @(negedge clock_in) begin
    if (!supply_valid_in) begin
      pin_n_out <= 1'b0;
      count     <= settle_cycles + low_cycles;
    end else if (request_in && count == 0) begin
      pin_n_out <= 1'b0;
      count     <= low_cycles;
    end else if (count > 1) begin
      count <= count - 1;
    end else if (count == 1) begin
      count     <= 0;
      pin_n_out <= 1'b1;
    end
  end
endmodule

// ==== verification/reset_source_sequencer_bench.sv ====
// self-checking bench for the reset source sequencer
// assumes the pin driver model and a shortened release count of 4
module reset_source_sequencer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import reset_seq_pkg::*;
  localparam int count_target = 4;
  logic clock_in = 0, reset_n_in = 0, supply_valid = 0, pin_request = 0, slow_osc = 0;
  logic vmon0_low = 0, vmon1_low = 0, vmon2_low = 0, wdt_uf = 0, wdt_sel = 0, sw_reset = 0;
  logic det0_en = 1, erased = 0, pin_n, pin_busy, sys_n, sfr_n, fetch, cpu_en, ok, ram_blk;
  logic vm0_en = 1, vm0_mode = 1;
  logic [7:0]  flash_byte = 8'hdf;
  logic [7:0]  opt;
  logic [2:0]  cause;
  logic [19:0] oe;
  int errors = 0, n_compared = 0, cycles = 0;
  always #2 clock_in = ~clock_in;
  reset_pin_driver partner (.clock_in(clock_in), .supply_valid_in(supply_valid), .request_in(pin_request),
    .pin_n_out(pin_n), .busy_out(pin_busy));
  reset_source_sequencer #(.count_target(count_target)) dut (.clock_in(clock_in), .reset_n_in(reset_n_in),
    .reset_pin_n_in(pin_n), .slow_osc_in(slow_osc), .vmon0_low_in(vmon0_low), .vmon1_low_in(vmon1_low),
    .vmon2_low_in(vmon2_low), .vmon1_reset_enable_in(1'b1), .vmon2_reset_enable_in(1'b1),
    .watchdog_underflow_in(wdt_uf), .watchdog_reset_select_in(wdt_sel), .software_reset_bit_in(sw_reset),
    .vmon0_reset_enable_in(vm0_en), .vmon0_reset_mode_select_in(vm0_mode), .detect0_circuit_enable_in(det0_en),
    .flash_option_byte_in(flash_byte), .flash_block_erased_in(erased), .system_reset_n_out(sys_n),
    .sfr_reset_n_out(sfr_n), .fetch_reset_vector_out(fetch), .reset_cause_out(cause),
    .option_select_byte_out(opt), .cpu_clock_enable_out(cpu_en), .port_output_enable_out(oe),
    .ram_write_block_out(ram_blk));
  ////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clock_in);
  endtask
  task automatic osc_edges(input int n);
    repeat (n) begin
      tick(4);
      slow_osc = 1'b1;
      tick(4);
      slow_osc = 1'b0;
    end
  endtask
  task automatic wait_run(input int max);
    ok = 1'b0;
    for (int i = 0; i < max && !ok; i++) begin
      tick(1);
      if (i % 4 == 0) slow_osc = ~slow_osc;
      ok = (sys_n === 1'b1);
    end
  endtask
  task automatic expect_release(input logic [2:0] exp_cause);
    wait_run(3000);
    check(ok, 1, "reset never released");
    check(fetch, 1, "no fetch pulse at release");
    check(cause, exp_cause, "wrong reset cause");
    check(ram_blk, 0, "ram still blocked after release");
    tick(1);
    check(fetch, 0, "fetch pulse too long");
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic pin_reset(input logic [7:0] exp_opt);
    tick(1);
    pin_request = 1'b1;
    tick(2);
    pin_request = 1'b0;
    tick(5);
    check(sys_n, 0, "pin low without reset");
    check(ram_blk, 1, "ram not blocked in reset");
    check(sfr_n, 0, "registers not reset by pin");
    check(oe, 20'h1 << port4_output_index, "port directions in pin reset");
    for (int i = 0; i < 3000 && pin_busy; i++) tick(1);
    check(sys_n, 0, "released before pin rose");
    expect_release(cause_pin);
    check(opt, exp_opt, "option byte latch");
    $display("pin reset test done");
  endtask
  task automatic vmon0_test();
    vmon0_low = 1'b1;
    tick(5);
    check(sys_n, 0, "monitor 0 low without reset");
    check(sfr_n, 0, "registers kept in monitor 0 reset");
    vmon0_low = 1'b0;
    osc_edges(2);
    vmon0_low = 1'b1;
    tick(5);
    vmon0_low = 1'b0;
    osc_edges(count_target - 1);
    tick(4);
    check(sys_n, 0, "release count not restarted");
    expect_release(cause_vmon0);
    $display("monitor 0 test done");
  endtask
  task automatic no_vmon0_reset();
    vmon0_low = 1'b1;
    tick(8);
    check(sys_n, 1, "disabled monitor 0 caused reset");
    vmon0_low = 1'b0;
    tick(4);
  endtask
  task automatic option_test();
    flash_byte = 8'hff;
    tick(10);
    check(opt, 8'hdf, "option changed without pin reset");
    pin_reset(8'hff);
    no_vmon0_reset();
    erased = 1'b1;
    flash_byte = 8'h00;
    pin_reset(option_erased_value);
    erased = 1'b0;
    flash_byte = 8'hdf;
    pin_reset(8'hdf);
    det0_en = 1'b0;
    no_vmon0_reset();
    det0_en = 1'b1;
    vm0_en = 1'b0;
    no_vmon0_reset();
    vm0_en = 1'b1;
    vm0_mode = 1'b0;
    no_vmon0_reset();
    vm0_mode = 1'b1;
    $display("option test done");
  endtask
  task automatic source_test(input int which, input logic hit, input logic [2:0] exp_cause);
    tick(1);
    case (which)
      0: wdt_uf = 1'b1;
      1: sw_reset = 1'b1;
      2: vmon1_low = 1'b1;
      default: vmon2_low = 1'b1;
    endcase
    tick(5);
    check(sys_n, !hit, "source reset level");
    check(sfr_n, 1, "excluded registers were reset");
    {wdt_uf, sw_reset, vmon1_low, vmon2_low} = 4'h0;
    if (hit) expect_release(exp_cause);
    else tick(4);
    $display("source %0d test done", which);
  endtask
  task automatic cpu_clock_test();
    int n;
    n = 0;
    for (int i = 0; i < 264; i++) begin
      tick(1);
      if (cpu_en === 1'b1) n++;
      if (i % 4 == 3 && i < 256) slow_osc = ~slow_osc;
    end
    check(n, 4, "cpu clock not slow divided by 8");
    $display("cpu clock test done");
  endtask
  ////////////////////////////////////////////////////////////////
  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 40000) begin
      errors++;
      $display("CHECK FAILED at %0t: timeout", $time);
      summarize();
    end
  end
  initial begin
    tick(4);
    reset_n_in = 1'b1;
    tick(2);
    supply_valid = 1'b1;
    wait_run(3500);
    check(ok, 1, "no start after power on");
    pin_reset(8'hdf);
    vmon0_test();
    option_test();
    source_test(0, 1'b0, cause_watchdog);
    wdt_sel = 1'b1;
    source_test(0, 1'b1, cause_watchdog);
    source_test(1, 1'b1, cause_software);
    source_test(2, 1'b1, cause_vmon1);
    source_test(3, 1'b1, cause_vmon2);
    cpu_clock_test();
    summarize();
  end
endmodule
